// ---- shared/usb_irq_pkg.sv ----
/*
 * Register map, field positions and reset values of the USB interrupt
 * enable and error-flag block.
 * Assumes a 32-bit APB slave with byte addresses = 4 x register index.
 */
package usb_irq_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] STATUS_IRQ_ENABLE_IDX = 12'hf36;
    localparam logic [11:0] ERROR_FLAG_IDX        = 12'hf63;
    localparam logic [11:0] ERROR_ENABLE_IDX      = 12'hf37;
    localparam logic [11:0] STATUS_FLAG_IDX       = 12'hf62;
    localparam logic [13:0] STATUS_IRQ_ENABLE_ADDR =
        {STATUS_IRQ_ENABLE_IDX, 2'b00};
    localparam logic [13:0] ERROR_FLAG_ADDR        = {ERROR_FLAG_IDX, 2'b00};
    localparam logic [13:0] ERROR_ENABLE_ADDR      = {ERROR_ENABLE_IDX, 2'b00};
    localparam logic [13:0] STATUS_FLAG_ADDR       = {STATUS_FLAG_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Status enable / status flag field positions
    // ------------------------------------------------------------------
    localparam int BUS_RESET_BIT   = 0;
    localparam int ERROR_BIT       = 1;
    localparam int BUS_ACTIVITY_BIT = 2;
    localparam int TRANSACTION_BIT = 3;
    localparam int IDLE_BIT        = 4;
    localparam int STALL_BIT       = 5;
    localparam int FRAME_START_BIT = 6;

    // ------------------------------------------------------------------
    // Error flag / error enable field positions
    // ------------------------------------------------------------------
    localparam int PID_ERR_BIT        = 0;
    localparam int TOKEN_CRC_ERR_BIT  = 1;
    localparam int DATA_CRC_ERR_BIT   = 2;
    localparam int DATA_SIZE_ERR_BIT  = 3;
    localparam int TURNAROUND_ERR_BIT = 4;
    localparam int STUFF_ERR_BIT      = 7;

    // Implemented-bit masks
    localparam logic [7:0] STATUS_ENABLE_MASK = 8'h7f;
    localparam logic [7:0] ERROR_MASK         = 8'h9f;
    localparam logic [7:0] STATUS_FLAG_MASK   = 8'h7d;

    // Reset values
    localparam logic [7:0] STATUS_IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] ERROR_FLAG_RESET        = 8'h00;
    localparam logic [7:0] ERROR_ENABLE_RESET      = 8'h00;
    localparam logic [7:0] STATUS_FLAG_RESET       = 8'h00;

endpackage

// ---- logic/usb_irq_enable_error_flags.sv ----
/*
 * USB interrupt enable and error-flag block: status enable register,
 * error flag register, error enable register, status flag register,
 * top-level error flag and module interrupt output, behind APB.
 * Assumes event inputs are single-cycle pulses from logic on sys_clk.
 */
// Operation
// - Each status enable bit passes its status flag to the interrupt.
// - Flags set on their events regardless of any enable bit.
// - Enable bits 6..0: frame, stall, idle, done, activity, error, reset.
// - Enabled error flags are ORed into the top-level error flag.
// - Error flag sets in the cycle its event is detected.
// - Error flag stays set until firmware writes zero to it.
// - Error bit 7 is bit stuff error; bits 6 and 5 read zero.
// - Error bit 4 is bus turnaround time-out.
// - Error bit 3 is non-integral data field size.
// - Error bit 2 is data CRC16 failure.
// - Error bit 1 is token CRC5 rejection.
// - Error bit 0 is PID check failure.
// - Error enable bits gate propagation only, never flag setting.
// - Top-level error flag is read-only, from enabled error flags.
// - Enabled status flags are ORed into the module interrupt.
// - Error enable mirrors error flags; bits 6 and 5 read zero.
`timescale 1ns/1ns

module usb_irq_enable_error_flags
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Status events from the serial interface engine
    input  wire logic        frameStartEvt,
    input  wire logic        stallEvt,
    input  wire logic        idleEvt,
    input  wire logic        transactionDoneEvt,
    input  wire logic        busActivityEvt,
    input  wire logic        busResetEvt,
    // Error events from the serial interface engine
    input  wire logic        stuffErrEvt,
    input  wire logic        turnaroundErrEvt,
    input  wire logic        dataSizeErrEvt,
    input  wire logic        dataCrcErrEvt,
    input  wire logic        tokenCrcErrEvt,
    input  wire logic        pidErrEvt,
    // Flag outputs
    output logic             topErrorFlag,
    output logic             moduleIrqFlag
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstSync1;
    logic rstSync2;

    // Asynchronous assert, two-flop synchronous release
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    wire logic rstSync_b = rstSync2;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic       wrAccess;
    logic       rdAccess;
    logic       addrHit;
    logic [7:0] wrByte;

    // Address match against the implemented registers
    function automatic logic isMapped(input logic [31:0] addr);
        isMapped = (addr == 32'(usb_irq_pkg::STATUS_IRQ_ENABLE_ADDR))
                 | (addr == 32'(usb_irq_pkg::ERROR_FLAG_ADDR))
                 | (addr == 32'(usb_irq_pkg::ERROR_ENABLE_ADDR))
                 | (addr == 32'(usb_irq_pkg::STATUS_FLAG_ADDR));
    endfunction

    // Zero-wait slave; writes take effect on the access edge
    always_comb
    begin
        addrHit  = isMapped(paddr);
        wrAccess = psel & penable & pwrite & addrHit & clkEn;
        rdAccess = psel & penable & ~pwrite & addrHit;
        wrByte   = pwdata[7:0];
        pready   = 1'b1;
        pslverr  = psel & penable & ~addrHit;
    end

    logic wrStatusEn;
    logic wrErrFlag;
    logic wrErrEn;
    logic wrStatusFlag;

    // Per-register write strobes, byte lane 0 only
    always_comb
    begin
        wrStatusEn   = wrAccess & pstrb[0]
                     & (paddr[13:0] == usb_irq_pkg::STATUS_IRQ_ENABLE_ADDR);
        wrErrFlag    = wrAccess & pstrb[0]
                     & (paddr[13:0] == usb_irq_pkg::ERROR_FLAG_ADDR);
        wrErrEn      = wrAccess & pstrb[0]
                     & (paddr[13:0] == usb_irq_pkg::ERROR_ENABLE_ADDR);
        wrStatusFlag = wrAccess & pstrb[0]
                     & (paddr[13:0] == usb_irq_pkg::STATUS_FLAG_ADDR);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  statusIrqEnable_reg;
    logic [7:0]  statusIrqEnable_next;
    logic [7:0]  errorFlag_reg;
    logic [7:0]  errorFlag_next;
    logic [7:0]  errorEnable_reg;
    logic [7:0]  errorEnable_next;
    logic [7:0]  statusFlag_reg;
    logic [7:0]  statusFlag_next;
    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic [7:0]  errEvents;
    logic [7:0]  statusEvents;
    logic        topErr;

    // Gather events into register layout
    always_comb
    begin
        errEvents = 8'h00;
        errEvents[usb_irq_pkg::STUFF_ERR_BIT]      = stuffErrEvt;
        errEvents[usb_irq_pkg::TURNAROUND_ERR_BIT] = turnaroundErrEvt;
        errEvents[usb_irq_pkg::DATA_SIZE_ERR_BIT]  = dataSizeErrEvt;
        errEvents[usb_irq_pkg::DATA_CRC_ERR_BIT]   = dataCrcErrEvt;
        errEvents[usb_irq_pkg::TOKEN_CRC_ERR_BIT]  = tokenCrcErrEvt;
        errEvents[usb_irq_pkg::PID_ERR_BIT]        = pidErrEvt;
        statusEvents = 8'h00;
        statusEvents[usb_irq_pkg::FRAME_START_BIT]  = frameStartEvt;
        statusEvents[usb_irq_pkg::STALL_BIT]        = stallEvt;
        statusEvents[usb_irq_pkg::IDLE_BIT]         = idleEvt;
        statusEvents[usb_irq_pkg::TRANSACTION_BIT]  = transactionDoneEvt;
        statusEvents[usb_irq_pkg::BUS_ACTIVITY_BIT] = busActivityEvt;
        statusEvents[usb_irq_pkg::BUS_RESET_BIT]    = busResetEvt;
    end

    // Top-level error from enabled error flags only
    always_comb
    begin
        topErr = |(errorFlag_reg & errorEnable_reg);
    end

    // Enable registers: plain read/write, reserved bits held at zero
    always_comb
    begin
        statusIrqEnable_next = statusIrqEnable_reg;
        errorEnable_next     = errorEnable_reg;
        if (wrStatusEn)
        begin
            statusIrqEnable_next =
                wrByte & usb_irq_pkg::STATUS_ENABLE_MASK;
        end
        if (wrErrEn)
        begin
            errorEnable_next = wrByte & usb_irq_pkg::ERROR_MASK;
        end
    end

    // Enable registers, frozen while clkEn is low
    always_ff @(posedge sys_clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            statusIrqEnable_reg <= usb_irq_pkg::STATUS_IRQ_ENABLE_RESET;
            errorEnable_reg     <= usb_irq_pkg::ERROR_ENABLE_RESET;
        end
        else if (clkEn)
        begin
            statusIrqEnable_reg <= statusIrqEnable_next;
            errorEnable_reg     <= errorEnable_next;
        end
    end

    // Error flags: write-zero clears, writing one leaves a flag alone
    always_comb
    begin
        errorFlag_next = errorFlag_reg;
        if (wrErrFlag)
        begin
            errorFlag_next = errorFlag_reg & wrByte;
        end
        // Events set regardless of enables, and win over a clear
        errorFlag_next = (errorFlag_next | errEvents)
                       & usb_irq_pkg::ERROR_MASK;
    end

    // Error flag register, frozen while clkEn is low
    always_ff @(posedge sys_clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            errorFlag_reg <= usb_irq_pkg::ERROR_FLAG_RESET;
        end
        else if (clkEn)
        begin
            errorFlag_reg <= errorFlag_next;
        end
    end

    // Status flags: firmware may clear by zero or set by one
    always_comb
    begin
        statusFlag_next = statusFlag_reg;
        if (wrStatusFlag)
        begin
            statusFlag_next = wrByte;
        end
        statusFlag_next = statusFlag_next | statusEvents;
        // Error bit is pure status, never written by firmware
        statusFlag_next[usb_irq_pkg::ERROR_BIT] = 1'b0;
        statusFlag_next = statusFlag_next & usb_irq_pkg::STATUS_FLAG_MASK;
    end

    // Status flag register, frozen while clkEn is low
    always_ff @(posedge sys_clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            statusFlag_reg <= usb_irq_pkg::STATUS_FLAG_RESET;
        end
        else if (clkEn)
        begin
            statusFlag_reg <= statusFlag_next;
        end
    end

    // Read data captured in the setup phase for the access phase
    always_comb
    begin
        rdData_next = 32'h0000_0000;
        if (psel & ~penable & ~pwrite)
        begin
            unique case (paddr[13:0])
                usb_irq_pkg::STATUS_IRQ_ENABLE_ADDR:
                    rdData_next = {24'h00_0000, statusIrqEnable_reg};
                usb_irq_pkg::ERROR_FLAG_ADDR:
                    rdData_next = {24'h00_0000, errorFlag_reg};
                usb_irq_pkg::ERROR_ENABLE_ADDR:
                    rdData_next = {24'h00_0000, errorEnable_reg};
                usb_irq_pkg::STATUS_FLAG_ADDR:
                    rdData_next = {24'h00_0000, statusFlag_reg};
                default:
                    rdData_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data register, frozen while clkEn is low
    always_ff @(posedge sys_clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            rdData_reg <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            rdData_reg <= rdData_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic [7:0] statusView;

    // Status flags as seen by software, error bit included
    always_comb
    begin
        statusView = statusFlag_reg;
        statusView[usb_irq_pkg::ERROR_BIT] = topErr;
        prdata = rdAccess ? rdData_reg : 32'h0000_0000;
        if (rdAccess
            && paddr[13:0] == usb_irq_pkg::STATUS_FLAG_ADDR)
        begin
            prdata = {24'h00_0000, statusView};
        end
        topErrorFlag  = topErr;
        moduleIrqFlag = |(statusView & statusIrqEnable_reg);
    end

endmodule

// ---- bench/usb_irq_checker_assertions.sv ----
/* Concurrent checks on the USB interrupt block's APB and flag ports.
   Assumes binding to the block's top module; sees only its ports. */
`timescale 1ns/1ns
module usb_irq_checker
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        topErrorFlag,
    input wire logic        moduleIrqFlag
);
    localparam logic [31:0] SE = {18'h0, usb_irq_pkg::STATUS_IRQ_ENABLE_ADDR};
    localparam logic [31:0] EF = {18'h0, usb_irq_pkg::ERROR_FLAG_ADDR};
    localparam logic [31:0] EE = {18'h0, usb_irq_pkg::ERROR_ENABLE_ADDR};
    localparam logic [31:0] SF = {18'h0, usb_irq_pkg::STATUS_FLAG_ADDR};
    logic rd;
    logic wr;
    // Access phase decode
    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_upper; rd |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_se7; rd && paddr == SE |-> !prdata[7]; endproperty
    a_se7: assert property (p_se7) else $error("enable bit 7 set");
    property p_ef65; rd && paddr == EF |-> prdata[6:5] == 2'b00;
    endproperty
    a_ef65: assert property (p_ef65) else $error("flag 6:5 set");
    property p_ee65; rd && paddr == EE |-> prdata[6:5] == 2'b00;
    endproperty
    a_ee65: assert property (p_ee65) else $error("enable 6:5 set");
    property p_mir; rd && paddr == SF |-> prdata[1] == topErrorFlag;
    endproperty
    a_mir: assert property (p_mir) else $error("status bit 1 wrong");
    property p_src; rd && paddr == EF && topErrorFlag |-> |prdata[7:0];
    endproperty
    a_src: assert property (p_src) else $error("top flag no source");
    property p_tfall; $fell(topErrorFlag) |-> $past(wr); endproperty
    a_tfall: assert property (p_tfall) else $error("top flag lost");
    property p_ifall; $fell(moduleIrqFlag) |-> $past(wr); endproperty
    a_ifall: assert property (p_ifall) else $error("irq lost");
endmodule

bind usb_irq_enable_error_flags usb_irq_checker i_chk (.sys_clk, .rst_b,
    .psel, .penable, .pwrite, .paddr, .pready, .prdata, .topErrorFlag,
    .moduleIrqFlag);

// ---- bench/sie_event_model.sv ----
/* Serial engine stand-in: turns a bench request into one-cycle events.
   Assumes the bench raises fire for one cycle; bits 7:0 error, 15:8 status. */
`timescale 1ns/1ns
module engine_event_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] fire,
    output logic      [15:0] evtQ
);
    // Event pulses launched one edge after the request
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evtQ <= 16'h0000;
        end
        else
        begin
            evtQ <= fire;
        end
    end
endmodule

// ---- bench/usb_irq_enable_error_flags_tb.sv ----
/* Testbench of the USB interrupt block: APB register tests and events.
   Assumes the block answers APB with zero wait states. */
`timescale 1ns/1ns
module usb_irq_enable_error_flags_tb;
    logic        sys_clk = 0, rst_b = 0, clkEn = 1, ev;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, topErrorFlag, moduleIrqFlag;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rv;
    logic [15:0] fire = '0, evtQ;
    logic [7:0]  m;
    int          n_errors = 0, samples_checked = 0;
    int          eb[6] = '{7, 4, 3, 2, 1, 0};
    int          sb[6] = '{6, 5, 4, 3, 2, 0};
    localparam logic [13:0] SE = usb_irq_pkg::STATUS_IRQ_ENABLE_ADDR;
    localparam logic [13:0] EF = usb_irq_pkg::ERROR_FLAG_ADDR;
    localparam logic [13:0] EE = usb_irq_pkg::ERROR_ENABLE_ADDR;
    localparam logic [13:0] SF = usb_irq_pkg::STATUS_FLAG_ADDR;

    usb_irq_enable_error_flags i_dut (.sys_clk, .rst_b, .clkEn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb(4'h1), .pready, .prdata,
        .pslverr, .frameStartEvt(evtQ[14]), .stallEvt(evtQ[13]),
        .idleEvt(evtQ[12]), .transactionDoneEvt(evtQ[11]),
        .busActivityEvt(evtQ[10]), .busResetEvt(evtQ[8]),
        .stuffErrEvt(evtQ[7]), .turnaroundErrEvt(evtQ[4]),
        .dataSizeErrEvt(evtQ[3]), .dataCrcErrEvt(evtQ[2]),
        .tokenCrcErrEvt(evtQ[1]), .pidErrEvt(evtQ[0]), .topErrorFlag,
        .moduleIrqFlag);
    engine_event_model i_engine (.sys_clk, .rst_b, .fire, .evtQ);

    // Clock, 8 ns period
    initial
        forever #4 sys_clk = ~sys_clk;

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; f fires events during its access phase
    task automatic xfer(input logic w, input logic [13:0] a,
                        input logic [7:0] d, input logic [15:0] f);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {18'h0, a};
        pwdata <= {24'h0, d};
        fire <= f;
        @(posedge sys_clk);
        penable <= 1;
        fire <= '0;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rdchk(input logic [13:0] a, input logic [32:0] exp);
        xfer(0, a, 8'h00, 16'h0);
        chk({ev, rv}, exp);
    endtask

    task automatic flags(input logic [1:0] exp);
        @(negedge sys_clk);
        chk({topErrorFlag, moduleIrqFlag}, {31'h0, exp});
    endtask

    task automatic close_out;
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        close_out();
    end

    // Test sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1;
        repeat (3) @(posedge sys_clk);
        rdchk(SE, 0);
        rdchk(EE, 0);
        rdchk(EF, 0);
        xfer(1, SE, 8'hff, 0);
        rdchk(SE, 33'h7f);
        xfer(1, EE, 8'hff, 0);
        rdchk(EE, 33'h9f);
        xfer(1, EE, 8'h00, 0);
        clkEn <= 0;
        xfer(1, SE, 8'h02, 0);
        clkEn <= 1;
        rdchk(SE, 33'h7f);
        xfer(1, SE, 8'h02, 0);
        xfer(1, SF, 8'h02, 0);
        rdchk(SF, 0);
        rdchk(14'h0000, 33'h100000000);
        $display("register test done");
        foreach (eb[i])
        begin
            m = 8'h01 << eb[i];
            xfer(0, EF, 8'h00, {8'h0, m});
            rdchk(EF, m);
            flags(2'b00);
            xfer(1, EE, m, 0);
            flags(2'b11);
            xfer(1, EF, 8'h00, {8'h0, m});
            rdchk(EF, m);
            xfer(1, EF, 8'hff, 0);
            rdchk(EF, m);
            xfer(1, EF, ~m, 0);
            rdchk(EF, 0);
            flags(2'b00);
            xfer(1, EE, 8'h00, 0);
        end
        $display("error flag test done");
        xfer(1, SE, 8'h00, 0);
        foreach (sb[i])
        begin
            m = 8'h01 << sb[i];
            xfer(0, SF, 8'h00, {m, 8'h0});
            rdchk(SF, m);
            flags(2'b00);
            xfer(1, SE, m, 0);
            flags(2'b01);
            xfer(1, SF, 8'h00, 0);
            flags(2'b00);
            xfer(1, SE, 8'h00, 0);
        end
        $display("status flag test done");
        close_out();
    end
endmodule
